//--- hdl/svw_align.sv
// Places a short received word into a byte with zero fill in the unused bits.
// Assumes len is 1 to 8 and that unreceived shift bits are already zero.
`timescale 1ns/1ns
module svw_align (
  // Shift register content and word length
  input wire logic [7:0] sh,
  input wire logic [3:0] len,
  input wire logic least_significant_first,
  // Aligned byte
  output logic [7:0] aligned
);

  ////////////////////////////////////////////////////////////////////////////
  // Shift the received bits to the kept end; shifting brings in zeros
  logic [3:0] pad;
  assign pad = svw_pkg::BYTE_BITS - len;
  assign aligned = least_significant_first ? (sh >> pad) : (sh << pad); // RL4 RL5

endmodule // svw_align

//--- hdl/svw_pkg.sv
// Constants and state type for the variable-width serial transfer counter block.
// Assumes a single 25 MHz system clock; every slower rate comes from an enable.
package svw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_WIDTH = 4'h1;
  localparam logic [3:0] REG_COUNT = 4'h2;
  localparam logic [3:0] REG_TXDATA = 4'h3;
  localparam logic [3:0] REG_RXDATA = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  localparam logic [3:0] REG_INT_STAT = 4'h6;
  localparam logic [3:0] REG_INT_MASK = 4'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_W = 6;
  localparam int CTRL_EN = 0;
  localparam int CTRL_MASTER = 1;
  localparam int CTRL_MODE = 2; // count_mode_selector, 1 = variable size
  localparam int CTRL_LEAST_SIGNIFICANT_FIRST = 3; // least_significant_first
  localparam int CTRL_TXEN = 4;
  localparam int CTRL_RXEN = 5;
  localparam int STAT_BUSY = 0;
  localparam int STAT_TXF = 1;
  localparam int STAT_RXF = 2;
  localparam int INT_W = 3;
  localparam int INT_CZ = 0; // counter_zero_flag
  localparam int INT_RXD = 1;
  localparam int INT_OVF = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and reset values
  localparam int WIDTH_W = 3;
  localparam int BYTE_W = 8;
  localparam int BITS_W = 4;
  localparam int CNT_W = 16;
  localparam int DIV_W = 8;
  localparam logic [BITS_W-1:0] BYTE_BITS = 4'h8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [INT_W-1:0] MASK_RST = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_NS = 40;
  localparam int SCLK_PERIOD_NS = 320;
  localparam int SCLK_HALF_RAW = SCLK_PERIOD_NS / (2 * CLK_NS);
  localparam int SCLK_HALF_CYCLES = (SCLK_HALF_RAW < 1) ? 1 : SCLK_HALF_RAW;

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SHIFT = 2'b10
  } svw_state_t;

  typedef struct packed {
    svw_state_t state;
    logic [CTRL_W-1:0] ctrl;
    logic [WIDTH_W-1:0] width;
    logic [CNT_W-1:0] count;
    logic [BYTE_W-1:0] tx_buf;
    logic tx_full;
    logic [BYTE_W-1:0] rx_buf;
    logic rx_full;
    logic [BYTE_W-1:0] tx_sh;
    logic [BYTE_W-1:0] rx_sh;
    logic [BITS_W-1:0] bit_cnt;
    logic [BITS_W-1:0] len;
    logic [DIV_W-1:0] div_cnt;
    logic sclk;
    logic ss_n_out;
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_s3;
    logic sdi_s1;
    logic sdi_s2;
    logic ss_n_s1;
    logic ss_n_s2;
    logic [INT_W-1:0] int_st;
    logic [INT_W-1:0] int_mask;
    logic [DATA_W-1:0] rdata;
  } svw_regs_t;

endpackage

//--- hdl/svw_xfer.sv
// Serial transfer engine with transfer counter, variable word width and registers.
// Assumes pins come from outside the clock domain and a master changing strobes
// right after the rising clock edge.
//
// Functional notes
// RL1 - Mode bit set: width is bits per transfer, count is number of transfers.
// RL2 - Variable mode with width zero makes each transfer a full byte.
// RL3 - Nonzero width: send only that many bits of each byte, drop the rest.
// RL4 - Short received words are zero filled before entering the receive buffer.
// RL5 - Bit order bit picks which end is dropped on send and padded on receive.
// RL6 - Variable mode: zero count halts only receive-only operation.
// RL7 - Variable mode counter wraps below zero instead of saturating.
// RL8 - Receive-only master in variable mode stops clocking at count zero.
// RL9 - Counter reaching zero sets the counter zero flag in both modes.
// RL10 - Counter still decrements per transfer in variable mode and slave mode.
// RL11 - A control bit selects total-bit-count or variable-size counting.
// RL12 - Variable mode counter drops by exactly one per finished transfer.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
module svw_xfer #(
  parameter int SCLK_HALF = svw_pkg::SCLK_HALF_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [svw_pkg::ADDR_W-1:0] addr,
  input wire logic [svw_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [svw_pkg::DATA_W-1:0] rdata,
  // Interrupt
  output logic irq,
  // Serial clock pin
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe,
  // Select pin, active low
  input wire logic ss_n_i,
  output logic ss_n_o,
  output logic ss_n_oe,
  // Data pins
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe
);

  initial begin
    if (SCLK_HALF < 1 || SCLK_HALF > 255) begin
      $error("SCLK_HALF out of range");
    end
  end

  svw_pkg::svw_regs_t r;
  svw_pkg::svw_regs_t n;
  logic en, master, vmode, least_significant_first, tx_en, rx_en, rx_only;
  logic s_rise, s_fall, tick, start, done, cnt_ok;
  logic [3:0] len_calc;
  logic [7:0] rx_shifted, align_in, aligned;
  logic [15:0] cnt_dec;

  ////////////////////////////////////////////////////////////////////////////
  // Control decode
  assign en = r.ctrl[svw_pkg::CTRL_EN];
  assign master = r.ctrl[svw_pkg::CTRL_MASTER];
  assign vmode = r.ctrl[svw_pkg::CTRL_MODE]; // RL11
  assign least_significant_first = r.ctrl[svw_pkg::CTRL_LEAST_SIGNIFICANT_FIRST];
  assign tx_en = r.ctrl[svw_pkg::CTRL_TXEN];
  assign rx_en = r.ctrl[svw_pkg::CTRL_RXEN];
  assign rx_only = rx_en & ~tx_en;

  // Edges of the synchronised serial clock; stage one is never looked at
  assign s_rise = r.sclk_s2 & ~r.sclk_s3;
  assign s_fall = ~r.sclk_s2 & r.sclk_s3;
  assign tick = (r.div_cnt == svw_pkg::DIV_W'(SCLK_HALF - 1));

  // Word length: width in variable mode, else up to a byte of the bit total
  always_comb begin
    if (vmode) begin
      len_calc = (r.width == '0) ? svw_pkg::BYTE_BITS : {1'b0, r.width}; // RL1 RL2
    end else if (r.count < svw_pkg::CNT_W'(svw_pkg::BYTE_BITS)) begin
      len_calc = r.count[3:0];
    end else begin
      len_calc = svw_pkg::BYTE_BITS;
    end
  end

  // Zero count only blocks receive-only in variable mode; total mode always
  assign cnt_ok = vmode ? (~rx_only | (r.count != '0)) : (r.count != '0); // RL6 RL8

  // Received byte including the bit sampled this cycle
  assign rx_shifted = least_significant_first ? {r.sdi_s2, r.rx_sh[7:1]} : {r.rx_sh[6:0], r.sdi_s2};
  assign align_in = master ? r.rx_sh : rx_shifted;

  svw_align u_align (
    .sh(align_in),
    .len(r.len),
    .least_significant_first(least_significant_first),
    .aligned(aligned)
  );

  // Variable mode wraps by one; total mode takes the bits just moved
  assign cnt_dec = vmode ? (r.count - 16'h0001) : // RL7 RL12
                   ((r.count == '0) ? r.count : (r.count - svw_pkg::CNT_W'(r.len)));

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n = r;
    start = 1'b0;
    done = 1'b0;
    n.rdata = '0;
    // Two flops on every pin before use
    n.sclk_s1 = sclk_i;
    n.sclk_s2 = r.sclk_s1;
    n.sclk_s3 = r.sclk_s2;
    n.sdi_s1 = sdi_i;
    n.sdi_s2 = r.sdi_s1;
    n.ss_n_s1 = ss_n_i;
    n.ss_n_s2 = r.ss_n_s1;

    // Software clears first so that hardware sets in the same cycle win
    if (wr && addr == svw_pkg::REG_INT_STAT) begin
      n.int_st = r.int_st & ~wdata[svw_pkg::INT_W-1:0];
    end
    if (rd && addr == svw_pkg::REG_RXDATA) begin
      n.rx_full = 1'b0;
    end

    unique case (r.state)
      svw_pkg::ST_IDLE: begin
        n.bit_cnt = '0;
        n.div_cnt = '0;
        if (en && master) begin
          start = cnt_ok & (tx_en ? r.tx_full : (rx_en & ~r.rx_full)); // RL8
        end else if (en && !r.ss_n_s2) begin
          start = 1'b1;
        end
        if (start) begin
          n.tx_sh = (tx_en && r.tx_full) ? r.tx_buf : '0;
          n.tx_full = r.tx_full & ~tx_en;
          n.rx_sh = '0;
          n.len = len_calc;
          n.ss_n_out = ~master;
          n.sclk = 1'b0;
          n.state = svw_pkg::ST_SHIFT;
        end
      end
      svw_pkg::ST_SHIFT: begin
        if (master) begin
          n.div_cnt = tick ? '0 : r.div_cnt + 8'h01;
          if (tick && !r.sclk) begin
            n.sclk = 1'b1;
            n.rx_sh = rx_shifted;
            n.bit_cnt = r.bit_cnt + 4'h1;
          end else if (tick) begin
            n.sclk = 1'b0;
            if (r.bit_cnt == r.len) begin
              done = 1'b1; // RL3
            end else begin
              n.tx_sh = least_significant_first ? {1'b0, r.tx_sh[7:1]} : {r.tx_sh[6:0], 1'b0}; // RL3 RL5
            end
          end
        end else if (r.ss_n_s2) begin
          // Select released mid word: drop the partial word
          n.state = svw_pkg::ST_IDLE;
        end else if (s_rise) begin
          n.rx_sh = rx_shifted;
          n.bit_cnt = r.bit_cnt + 4'h1;
          done = (r.bit_cnt + 4'h1 == r.len); // RL3
        end else if (s_fall && r.bit_cnt != '0) begin
          n.tx_sh = least_significant_first ? {1'b0, r.tx_sh[7:1]} : {r.tx_sh[6:0], 1'b0}; // RL3 RL5
        end
      end
    endcase

    // End of a word: store, count down, raise flags
    if (done) begin
      n.state = svw_pkg::ST_IDLE;
      n.ss_n_out = 1'b1;
      n.count = cnt_dec; // RL10 RL12
      if (cnt_dec == '0 && r.count != '0) begin
        n.int_st[svw_pkg::INT_CZ] = 1'b1; // RL9
      end
      if (rx_en && r.rx_full && !(rd && addr == svw_pkg::REG_RXDATA)) begin
        n.int_st[svw_pkg::INT_OVF] = 1'b1;
      end else if (rx_en) begin
        n.rx_buf = aligned; // RL4
        n.rx_full = 1'b1;
        n.int_st[svw_pkg::INT_RXD] = 1'b1;
      end
    end

    // Disabling stops everything at once
    if (!en) begin
      n.state = svw_pkg::ST_IDLE;
      n.sclk = 1'b0;
      n.ss_n_out = 1'b1;
    end

    // Software writes; a new byte or count taken now overrides the engine
    if (wr) begin
      unique case (addr)
        svw_pkg::REG_CTRL: n.ctrl = wdata[svw_pkg::CTRL_W-1:0];
        svw_pkg::REG_WIDTH: n.width = wdata[svw_pkg::WIDTH_W-1:0];
        svw_pkg::REG_COUNT: n.count = wdata;
        svw_pkg::REG_TXDATA: begin
          n.tx_buf = wdata[svw_pkg::BYTE_W-1:0];
          n.tx_full = 1'b1;
        end
        svw_pkg::REG_INT_MASK: n.int_mask = wdata[svw_pkg::INT_W-1:0];
        default: begin
        end
      endcase
    end

    // Read data stands for the single cycle after the strobe
    if (rd) begin
      unique case (addr)
        svw_pkg::REG_CTRL: n.rdata = {10'h000, r.ctrl};
        svw_pkg::REG_WIDTH: n.rdata = {13'h0000, r.width};
        svw_pkg::REG_COUNT: n.rdata = r.count;
        svw_pkg::REG_RXDATA: n.rdata = {8'h00, r.rx_buf};
        svw_pkg::REG_STATUS: n.rdata = {13'h0000, r.rx_full, r.tx_full,
                                        r.state == svw_pkg::ST_SHIFT};
        svw_pkg::REG_INT_STAT: n.rdata = {13'h0000, r.int_st};
        svw_pkg::REG_INT_MASK: n.rdata = {13'h0000, r.int_mask};
        default: n.rdata = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
      r.state <= svw_pkg::ST_IDLE;
      r.ctrl <= svw_pkg::CTRL_RST;
      r.int_mask <= svw_pkg::MASK_RST;
      r.ss_n_out <= 1'b1;
      r.ss_n_s1 <= 1'b1;
      r.ss_n_s2 <= 1'b1;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; pin enables follow the role, slave data only while selected
  assign rdata = r.rdata;
  assign irq = |(r.int_st & r.int_mask);
  assign sclk_o = r.sclk;
  assign sclk_oe = en & master;
  assign ss_n_o = r.ss_n_out;
  assign ss_n_oe = en & master;
  assign sdo_o = least_significant_first ? r.tx_sh[0] : r.tx_sh[7];
  assign sdo_oe = en & (master | ~r.ss_n_s2);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_len_width;
    @(posedge clk) disable iff (sys_rst)
      start && vmode && r.width != '0 |=> r.len == {1'b0, $past(r.width)};
  endproperty
  a_len_width: assert property (p_len_width) else $error("word length not width"); // RL1

  property p_len_byte;
    @(posedge clk) disable iff (sys_rst)
      start && vmode && r.width == '0 |=> r.len == svw_pkg::BYTE_BITS;
  endproperty
  a_len_byte: assert property (p_len_byte) else $error("zero width not a byte"); // RL2

  property p_bits_sent;
    @(posedge clk) disable iff (sys_rst)
      done && master |-> r.bit_cnt == r.len && r.sclk;
  endproperty
  a_bits_sent: assert property (p_bits_sent) else $error("wrong bit count"); // RL3

  property p_pad_zero;
    @(posedge clk) disable iff (sys_rst)
      done && rx_en && !r.rx_full |=>
        (least_significant_first ? (r.rx_buf >> $past(r.len)) : (r.rx_buf << $past(r.len))) == 8'h00;
  endproperty
  a_pad_zero: assert property (p_pad_zero) else $error("padding not zero"); // RL4 RL5

  property p_rxonly_halt;
    @(posedge clk) disable iff (sys_rst)
      r.state == svw_pkg::ST_IDLE && en && master && vmode && rx_only && r.count == '0
      |-> !start ##1 !r.sclk;
  endproperty
  a_rxonly_halt: assert property (p_rxonly_halt) else $error("clock at zero count"); // RL8

  property p_tx_runs;
    @(posedge clk) disable iff (sys_rst)
      r.state == svw_pkg::ST_IDLE && en && master && vmode && tx_en && r.tx_full
      |-> start;
  endproperty
  a_tx_runs: assert property (p_tx_runs) else $error("zero count blocked send"); // RL6

  property p_dec_one;
    @(posedge clk) disable iff (sys_rst)
      done && vmode && !wr |=> r.count == $past(r.count) - 16'h0001;
  endproperty
  a_dec_one: assert property (p_dec_one) else $error("count not down by one"); // RL7 RL12

  property p_cz_flag;
    @(posedge clk) disable iff (sys_rst)
      done && r.count == 16'h0001 && vmode |=> r.int_st[svw_pkg::INT_CZ] ##1 irq ||
        !r.int_mask[svw_pkg::INT_CZ] || r.int_st[svw_pkg::INT_CZ] == 1'b0;
  endproperty
  a_cz_flag: assert property (p_cz_flag) else $error("zero flag missing"); // RL9

  property p_slave_count;
    @(posedge clk) disable iff (sys_rst)
      done && !master && vmode && !wr |=> r.count != $past(r.count);
  endproperty
  a_slave_count: assert property (p_slave_count) else $error("slave no count"); // RL10

  property p_total_halt;
    @(posedge clk) disable iff (sys_rst)
      r.state == svw_pkg::ST_IDLE && master && !vmode && r.count == '0 |-> !start;
  endproperty
  a_total_halt: assert property (p_total_halt) else $error("total mode ran at zero"); // RL11

endmodule // svw_xfer

//--- verification/svw_slave_model.sv
// Serial slave model standing on the far side of the block in master mode.
// Assumes an idle-low serial clock, data changed on the falling edge, sampled on rising.
`timescale 1ns/1ns
module svw_slave_model #(
  parameter logic [7:0] PATTERN = 8'hB5
) (
  // Pins from the master
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic least_significant_first,
  // Pin to the master
  output logic miso,
  // Last captured bits
  output logic [7:0] cap
);
  int idx;

  ////////////////////////////////////////////////////////////////////////////
  // First bit on select, next bit after each falling clock edge
  always @(negedge ss_n) begin
    idx = 0;
    miso = least_significant_first ? PATTERN[0] : PATTERN[7];
  end
  always @(negedge sclk) begin
    if (!ss_n) begin
      idx = idx + 1;
      miso = least_significant_first ? PATTERN[idx & 7] : PATTERN[7 - (idx & 7)];
    end
  end
  // Released line flips, so stale data never passes for a sample
  always @(posedge ss_n) miso = ~miso;

  ////////////////////////////////////////////////////////////////////////////
  // Capture in the direction that the bit order implies
  always @(posedge sclk) begin
    if (!ss_n) cap = least_significant_first ? {mosi, cap[7:1]} : {cap[6:0], mosi};
  end
  initial begin
    miso = 1'b0;
    cap = 8'h00;
    idx = 0;
  end
endmodule // svw_slave_model

//--- verification/tb.sv
// Self-checking bench for the serial transfer engine in master and slave mode.
// Assumes the slave model on the pins in master mode and the bench as link master otherwise.
`timescale 1ns/1ns
module tb;
  typedef struct packed {
    logic mode;
    logic least_significant_first;
    logic [2:0] width;
    logic [15:0] count;
    logic [7:0] tx;
  } svw_row_t;
  localparam logic [7:0] PAT = 8'hB5;
  localparam int NROW = 9;
  // Mode, bit order, width, count, transmit byte
  localparam svw_row_t ROWS [NROW] = '{
    '{1'b1, 1'b0, 3'h0, 16'h0005, 8'hA7}, '{1'b1, 1'b1, 3'h0, 16'h0001, 8'h3C},
    '{1'b1, 1'b0, 3'h3, 16'h0002, 8'hE1}, '{1'b1, 1'b1, 3'h3, 16'h0002, 8'h4E},
    '{1'b1, 1'b0, 3'h1, 16'h0007, 8'h80}, '{1'b1, 1'b1, 3'h7, 16'h0009, 8'hFE},
    '{1'b1, 1'b0, 3'h5, 16'h0000, 8'h5A}, '{1'b0, 1'b0, 3'h0, 16'h0003, 8'hC9},
    '{1'b0, 1'b1, 3'h0, 16'h0003, 8'h96}};

  logic clk, sys_rst, wr, rd, irq, least_significant_first_cfg, miso;
  logic [3:0] addr;
  logic [15:0] wdata, rdata;
  logic sclk_o, sclk_oe, ss_n_o, ss_n_oe, sdo_o, sdo_oe;
  logic [7:0] cap;
  logic m_sclk, m_ss_n, m_mosi;
  int err_count = 0;
  int check_count = 0;
  int sclk_rises = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Design and far side; released pins fall back to idle or flipped levels
  svw_xfer u_svw_xfer (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .sclk_i(m_sclk), .sclk_o(sclk_o), .sclk_oe(sclk_oe),
    .ss_n_i(m_ss_n), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe), .sdi_i(ss_n_oe ? miso : m_mosi),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe));
  svw_slave_model #(.PATTERN(PAT)) u_svw_slave_model (.sclk(sclk_oe & sclk_o),
    .ss_n(~ss_n_oe | ss_n_o), .mosi(sdo_oe ? sdo_o : ~sdo_o), .least_significant_first(least_significant_first_cfg), .miso(miso),
    .cap(cap));
  always @(posedge sclk_o) sclk_rises++;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus cycles, comparison and verdict
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Polling bounded so a dead engine ends in a mismatch, not a hang
  task automatic wait_rx;
    logic [15:0] v;
    v = 16'h0000;
    for (int k = 0; k < 200 && v[svw_pkg::STAT_RXF] !== 1'b1; k++) rd_reg(svw_pkg::REG_STATUS, v);
    chk("rx full", {15'h0000, v[svw_pkg::STAT_RXF]}, 16'h0001);
  endtask
  // Bench as link master for slave mode; half period of 4 system clocks, idle low
  task automatic mst_word(input logic [7:0] mo, input int nbits, output logic [7:0] mi);
    mi = 8'h00;
    @(posedge clk);
    m_ss_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int b = 0; b < nbits; b++) begin
      m_mosi <= mo[7 - b];
      repeat (4) @(posedge clk);
      m_sclk <= 1'b1;
      mi = {mi[6:0], sdo_o};
      repeat (4) @(posedge clk);
      m_sclk <= 1'b0;
    end
    // Hold select past the last edge so the word end is seen before release
    repeat (8) @(posedge clk);
    m_ss_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One word per row, full duplex
  task automatic run_row(input svw_row_t r);
    logic [15:0] v, cnt_exp;
    logic [3:0] len;
    logic [7:0] lowm, rx_exp;
    int rises0;
    len = r.mode ? ((r.width == 3'h0) ? 4'h8 : {1'b0, r.width}) :
      ((r.count > 16'h0008) ? 4'h8 : r.count[3:0]);
    cnt_exp = r.mode ? r.count - 16'h0001 : r.count - {12'h000, len};
    lowm = 8'hFF >> (4'h8 - len);
    rx_exp = r.least_significant_first ? (PAT & lowm) : (PAT & ~(8'hFF >> len));
    least_significant_first_cfg <= r.least_significant_first;
    wr_reg(svw_pkg::REG_WIDTH, {13'h0000, r.width});
    wr_reg(svw_pkg::REG_COUNT, r.count);
    wr_reg(svw_pkg::REG_INT_STAT, 16'h0007);
    wr_reg(svw_pkg::REG_CTRL, {10'h000, 2'b11, r.least_significant_first, r.mode, 2'b11});
    rises0 = sclk_rises;
    wr_reg(svw_pkg::REG_TXDATA, {8'h00, r.tx});
    wait_rx();
    rd_reg(svw_pkg::REG_RXDATA, v);
    chk("rx byte", v, {8'h00, rx_exp});
    chk("clock count", 16'(sclk_rises - rises0), {12'h000, len});
    if (r.least_significant_first) chk("sent bits", {8'h00, cap >> (4'h8 - len)}, {8'h00, r.tx & lowm});
    else chk("sent bits", {8'h00, cap & lowm}, {8'h00, r.tx >> (4'h8 - len)});
    rd_reg(svw_pkg::REG_COUNT, v);
    chk("counter", v, cnt_exp);
    rd_reg(svw_pkg::REG_INT_STAT, v);
    chk("zero flag", {15'h0000, v[0]}, {15'h0000, cnt_exp == 16'h0 && r.count != 16'h0});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [15:0] v;
    int rises0;
    logic [7:0] mi;
    sys_rst = 1'b1;
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    least_significant_first_cfg = 1'b0;
    m_sclk = 1'b0;
    m_ss_n = 1'b1;
    m_mosi = 1'b0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd_reg(svw_pkg::REG_CTRL, v);
    chk("ctrl reset", v, 16'h0000);
    rd_reg(svw_pkg::REG_INT_MASK, v);
    chk("mask reset", v, 16'h0000);
    rd_reg(4'h8, v);
    chk("unmapped read", v, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < NROW; i++) begin
      run_row(ROWS[i]);
      $display("test row %0d done", i);
    end
    // Receive-only master: two words, then the clock must stay still
    least_significant_first_cfg <= 1'b0;
    wr_reg(svw_pkg::REG_WIDTH, 16'h0002);
    wr_reg(svw_pkg::REG_INT_STAT, 16'h0007);
    wr_reg(svw_pkg::REG_COUNT, 16'h0002);
    rises0 = sclk_rises;
    wr_reg(svw_pkg::REG_CTRL, 16'h0027);
    for (int w = 0; w < 2; w++) begin
      wait_rx();
      rd_reg(svw_pkg::REG_RXDATA, v);
      chk("rx only byte", v, {8'h00, PAT & 8'hC0});
    end
    repeat (100) @(posedge clk);
    chk("rx only clocks", 16'(sclk_rises - rises0), 16'h0004);
    rd_reg(svw_pkg::REG_COUNT, v);
    chk("rx only counter", v, 16'h0000);
    rd_reg(svw_pkg::REG_INT_STAT, v);
    chk("rx only zero flag", {15'h0000, v[0]}, 16'h0001);
    $display("test receive only done");
    // Interrupt masked, unmasked, then cleared
    #1;
    chk("irq masked", {15'h0000, irq}, 16'h0000);
    wr_reg(svw_pkg::REG_INT_MASK, 16'h0001);
    #1;
    chk("irq raised", {15'h0000, irq}, 16'h0001);
    wr_reg(svw_pkg::REG_INT_STAT, 16'h0001);
    #1;
    chk("irq cleared", {15'h0000, irq}, 16'h0000);
    $display("test interrupt done");
    // Slave mode: one three-bit word driven by the bench ends the count
    wr_reg(svw_pkg::REG_CTRL, 16'h0035);
    wr_reg(svw_pkg::REG_WIDTH, 16'h0003);
    wr_reg(svw_pkg::REG_COUNT, 16'h0001);
    wr_reg(svw_pkg::REG_INT_STAT, 16'h0007);
    wr_reg(svw_pkg::REG_TXDATA, 16'h00C3);
    mst_word(8'h6D, 3, mi);
    chk("slave sent", {13'h0000, mi[2:0]}, 16'h0006);
    wait_rx();
    rd_reg(svw_pkg::REG_RXDATA, v);
    chk("slave rx byte", v, 16'h0060);
    rd_reg(svw_pkg::REG_COUNT, v);
    chk("slave counter", v, 16'h0000);
    rd_reg(svw_pkg::REG_INT_STAT, v);
    chk("slave zero flag", {15'h0000, v[0]}, 16'h0001);
    chk("slave irq", {15'h0000, irq}, 16'h0001);
    $display("test slave done");
    summarize();
  end

  // Watchdog well beyond the fewer than one thousand cycles the tests need
  initial begin
    #(40 * 30000);
    err_count++;
    $display("[ERR] watchdog expected finish seen timeout");
    summarize();
  end
endmodule // tb
